// >>> design/faae_top.sv
// automatic action enable register and safe-state trigger combining
// assumes the register port below comes from the device's register decode on ref_clk_i,
// and that event and fault-enable inputs are synchronous levels from neighbouring logic
`timescale 1ns/1ps
module faae_top
	import faae_pkg::*;
#(
	parameter int NOUT = FAAE_NUM_OUTPUTS,
	parameter int NXTAL = FAAE_NUM_XTALS
)
(
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	input wire logic [31:0] fault_en_i,
	input wire logic cal_timeout_event_i,
	input wire logic loader_crc_event_i,
	input wire logic bus_crc_event_i,
	input wire logic sig_reload_event_i,
	input wire logic sig_check_event_i,
	input wire logic dual_xtal_event_i,
	input wire logic xtal_switch_event_i,
	input wire logic [NOUT-1:0] output_frequency_event_i,
	input wire logic [NXTAL-1:0] crystal_short_term_error_i,
	input wire logic ppm_err_event_i,
	input wire logic ppm_warn_event_i,
	input wire logic [NXTAL-1:0] crystal_signal_loss_event_i,
	input wire logic pll_lol_event_i,
	input wire logic self_test_event_i,
	output logic [NOUT-1:0] output_disable_o,
	output logic safe_trigger_o
);
	logic [31:0] action_r;
	logic [31:0] rdata_nxt;
	logic [31:0] hit;
	logic freq_safe;
	logic safe_nxt;
	logic [NXTAL-1:0] crystal_short_term_safe_enables;

	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			action_r <= FAAE_ACTION_RESET;
		else if (reg_wr_i && reg_addr_i == FAAE_ACTION_OFFSET)
			action_r <= reg_wdata_i & FAAE_ACTION_WMASK;
	end

	// reserved positions never hold a one, whatever software writes
	chk_reserved_zero: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		(action_r & ~FAAE_ACTION_WMASK) == 32'h00000000
	)
		else $error("reserved bits set");

	chk_write_lands: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		reg_wr_i && reg_addr_i == FAAE_ACTION_OFFSET
		|=> action_r == ($past(reg_wdata_i) & FAAE_ACTION_WMASK)
	)
		else $error("write not stored");

	// writes elsewhere in the group belong to other registers
	chk_write_ignored: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		!(reg_wr_i && reg_addr_i == FAAE_ACTION_OFFSET)
		|=> $stable(action_r)
	)
		else $error("register changed without write");

	always_comb
	begin
		rdata_nxt = 32'h00000000;
		if (reg_addr_i == FAAE_ACTION_OFFSET)
			rdata_nxt = action_r;
	end

	// read data registered; unmapped offsets answer zero
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			reg_rdata_o <= 32'h00000000;
		else if (reg_rd_i)
			reg_rdata_o <= rdata_nxt;
	end

	chk_read_value: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		reg_rd_i && reg_addr_i == FAAE_ACTION_OFFSET
		|=> reg_rdata_o == $past(action_r)
	)
		else $error("read data wrong");

	chk_read_unmapped: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		reg_rd_i && reg_addr_i != FAAE_ACTION_OFFSET
		|=> reg_rdata_o == 32'h00000000
	)
		else $error("unmapped read not zero");

	// software may sample late, so read data must stand until the next strobe
	chk_read_holds: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		!reg_rd_i
		|=> $stable(reg_rdata_o)
	)
		else $error("read data moved");

	assign crystal_short_term_safe_enables = action_r[FAAE_ST_LSB +: NXTAL];

	always_comb
	begin
		hit = 32'h00000000;
		hit[FAAE_BIT_CAL_TIMEOUT] = cal_timeout_event_i;
		hit[FAAE_BIT_LOADER_CRC] = loader_crc_event_i;
		hit[FAAE_BIT_BUS_CRC] = bus_crc_event_i;
		hit[FAAE_BIT_SIG_RELOAD] = sig_reload_event_i;
		hit[FAAE_BIT_SIG_CHECK] = sig_check_event_i;
		hit[FAAE_BIT_DUAL_XTAL] = dual_xtal_event_i;
		hit[FAAE_BIT_XTAL_SWITCH] = xtal_switch_event_i;
		hit[FAAE_ST_LSB +: NXTAL] = crystal_short_term_error_i;
		hit[FAAE_BIT_PPM_ERR] = ppm_err_event_i;
		hit[FAAE_BIT_PPM_WARN] = ppm_warn_event_i;
		hit[FAAE_LOS_LSB +: NXTAL] = crystal_signal_loss_event_i;
		hit[FAAE_BIT_PLL_LOL] = pll_lol_event_i;
		hit[FAAE_BIT_SELF_TEST] = self_test_event_i;
		// freq bits handled in the gate, which also drives the disables
	end

	faae_freq_gate #(
		.N(NOUT)
	) u_freq (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.action_en_i(action_r[FAAE_FREQ_LSB +: NOUT]),
		.fault_en_i(fault_en_i[FAAE_FREQ_LSB +: NOUT]),
		.event_i(output_frequency_event_i),
		.output_disable_o(output_disable_o),
		.safe_req_o(freq_safe)
	);

	// the action enable and the fault enable must both be set
	assign safe_nxt = (|(hit & action_r & fault_en_i)) | freq_safe;

	// registered so the safe machinery sees a glitch-free level
	always_ff @(posedge ref_clk_i)
	begin
		if (srst_i)
			safe_trigger_o <= 1'b0;
		else
			safe_trigger_o <= safe_nxt;
	end

	// one check per single-bit source: action bit, fault enable and event together
	chk_cal_timeout: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		action_r[FAAE_BIT_CAL_TIMEOUT] && fault_en_i[FAAE_BIT_CAL_TIMEOUT] && cal_timeout_event_i
		|=> safe_trigger_o
	)
		else $error("cal timeout no safe");

	chk_loader_crc: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		action_r[FAAE_BIT_LOADER_CRC] && fault_en_i[FAAE_BIT_LOADER_CRC] && loader_crc_event_i
		|=> safe_trigger_o
	)
		else $error("loader crc no safe");

	chk_bus_crc: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		action_r[FAAE_BIT_BUS_CRC] && fault_en_i[FAAE_BIT_BUS_CRC] && bus_crc_event_i
		|=> safe_trigger_o
	)
		else $error("bus crc no safe");

	chk_sig_reload: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		action_r[FAAE_BIT_SIG_RELOAD] && fault_en_i[FAAE_BIT_SIG_RELOAD] && sig_reload_event_i
		|=> safe_trigger_o
	)
		else $error("reload no safe");

	chk_sig_check: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		action_r[FAAE_BIT_SIG_CHECK] && fault_en_i[FAAE_BIT_SIG_CHECK] && sig_check_event_i
		|=> safe_trigger_o
	)
		else $error("sig check no safe");

	chk_dual_xtal: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		action_r[FAAE_BIT_DUAL_XTAL] && fault_en_i[FAAE_BIT_DUAL_XTAL] && dual_xtal_event_i
		|=> safe_trigger_o
	)
		else $error("dual xtal no safe");

	chk_xtal_switch: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		action_r[FAAE_BIT_XTAL_SWITCH] && fault_en_i[FAAE_BIT_XTAL_SWITCH] && xtal_switch_event_i
		|=> safe_trigger_o
	)
		else $error("switch no safe");

	// the disable needs only the action bit; the fault enable gates just the safe request
	chk_freq_disable: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		1'b1
		|=> output_disable_o == $past(action_r[FAAE_FREQ_LSB +: NOUT] & output_frequency_event_i)
	)
		else $error("freq disable wrong");

	chk_freq_safe: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		|(action_r[FAAE_FREQ_LSB +: NOUT] & fault_en_i[FAAE_FREQ_LSB +: NOUT] & output_frequency_event_i)
		|=> safe_trigger_o
	)
		else $error("freq no safe");

	chk_short_term: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		|(crystal_short_term_safe_enables & fault_en_i[FAAE_ST_LSB +: NXTAL] & crystal_short_term_error_i)
		|=> safe_trigger_o
	)
		else $error("short term no safe");

	chk_ppm_err: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		action_r[FAAE_BIT_PPM_ERR] && fault_en_i[FAAE_BIT_PPM_ERR] && ppm_err_event_i
		|=> safe_trigger_o
	)
		else $error("ppm err no safe");

	chk_ppm_warn: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		action_r[FAAE_BIT_PPM_WARN] && fault_en_i[FAAE_BIT_PPM_WARN] && ppm_warn_event_i
		|=> safe_trigger_o
	)
		else $error("ppm warn no safe");

	chk_signal_loss: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		|(action_r[FAAE_LOS_LSB +: NXTAL] & fault_en_i[FAAE_LOS_LSB +: NXTAL] & crystal_signal_loss_event_i)
		|=> safe_trigger_o
	)
		else $error("los no safe");

	chk_pll_lol: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		action_r[FAAE_BIT_PLL_LOL] && fault_en_i[FAAE_BIT_PLL_LOL] && pll_lol_event_i
		|=> safe_trigger_o
	)
		else $error("lol no safe");

	chk_self_test: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		action_r[FAAE_BIT_SELF_TEST] && fault_en_i[FAAE_BIT_SELF_TEST] && self_test_event_i
		|=> safe_trigger_o
	)
		else $error("self test no safe");

	// the trigger is a level, not sticky: it drops as soon as no source asks
	chk_no_false_safe: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		!safe_nxt
		|=> !safe_trigger_o
	)
		else $error("spurious safe");

	chk_fault_gate: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		fault_en_i == 32'h00000000
		|=> !safe_trigger_o
	)
		else $error("safe without fault enable");

	chk_actions_off: assert property (
		@(posedge ref_clk_i) disable iff (srst_i)
		action_r == 32'h00000000
		|=> !safe_trigger_o && output_disable_o == {NOUT{1'b0}}
	)
		else $error("action without enable");

	// no disable clause here: this one watches the reset itself
	chk_reset_clears: assert property (
		@(posedge ref_clk_i)
		srst_i
		|=> action_r == FAAE_ACTION_RESET && reg_rdata_o == 32'h00000000
			&& !safe_trigger_o && output_disable_o == {NOUT{1'b0}}
	)
		else $error("reset left state behind");
endmodule

// >>> design/faae_pkg.sv
// package for the automatic action enable block: register offset, field layout, reset value
// assumes the register sits at offset zero of the interrupt/fault register group
package faae_pkg;
	localparam logic [7:0] FAAE_ACTION_OFFSET = 8'h00;
	localparam logic [31:0] FAAE_ACTION_RESET = 32'h00000000;
	localparam logic [31:0] FAAE_ACTION_WMASK = 32'h17FFFFFD;
	localparam int FAAE_BIT_CAL_TIMEOUT = 28;
	localparam int FAAE_BIT_LOADER_CRC = 26;
	localparam int FAAE_BIT_BUS_CRC = 25;
	localparam int FAAE_BIT_SIG_RELOAD = 24;
	localparam int FAAE_BIT_SIG_CHECK = 23;
	localparam int FAAE_BIT_DUAL_XTAL = 22;
	localparam int FAAE_BIT_XTAL_SWITCH = 21;
	localparam int FAAE_FREQ_LSB = 9;
	localparam int FAAE_NUM_OUTPUTS = 12;
	localparam int FAAE_ST_LSB = 7;
	localparam int FAAE_NUM_XTALS = 2;
	localparam int FAAE_BIT_PPM_ERR = 6;
	localparam int FAAE_BIT_PPM_WARN = 5;
	localparam int FAAE_LOS_LSB = 3;
	localparam int FAAE_BIT_PLL_LOL = 2;
	localparam int FAAE_BIT_SELF_TEST = 0;
endpackage

// >>> design/faae_freq_gate.sv
// per-output frequency-event gating: direct output disable per output and one safe request ORed over all outputs
// assumes events and enables are on ref_clk_i; disable outputs are registered
`timescale 1ns/1ps
module faae_freq_gate
	import faae_pkg::*;
#(
	parameter int N = FAAE_NUM_OUTPUTS
)
(
	input wire logic ref_clk_i,
	input wire logic srst_i,
	input wire logic [N-1:0] action_en_i,
	input wire logic [N-1:0] fault_en_i,
	input wire logic [N-1:0] event_i,
	output logic [N-1:0] output_disable_o,
	output logic safe_req_o
);
	logic [N-1:0] hit;
	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_out
			assign hit[g] = action_en_i[g] & event_i[g] & fault_en_i[g];
			// disable holds until the event or the action bit drops; latched status lives elsewhere
			always_ff @(posedge ref_clk_i)
			begin
				if (srst_i)
					output_disable_o[g] <= 1'b0;
				else
					output_disable_o[g] <= action_en_i[g] & event_i[g];
			end
		end
	endgenerate
	assign safe_req_o = |hit;
endmodule

// >>> verif/faae_top_tb.sv
// self-checking bench for the automatic action enable block
// assumes faae_top with its default widths; all inputs change at the falling edge
`timescale 1ns/1ps
module faae_top_tb
	import faae_pkg::*;
;
	logic ref_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h00000000;
	logic [31:0] fault_en_i = 32'h00000000;
	// one event per register bit, so events share the action layout
	logic [31:0] ev = 32'h00000000;
	logic [31:0] rd_val;
	logic [31:0] reg_rdata_o;
	logic [11:0] output_disable_o;
	logic safe_trigger_o;
	int bad_count = 0;
	int cmp_count = 0;
	int cycles = 0;

	always #2.5 ref_clk_i = ~ref_clk_i;

	faae_top uut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .fault_en_i(fault_en_i),
		.cal_timeout_event_i(ev[28]), .loader_crc_event_i(ev[26]), .bus_crc_event_i(ev[25]),
		.sig_reload_event_i(ev[24]), .sig_check_event_i(ev[23]), .dual_xtal_event_i(ev[22]),
		.xtal_switch_event_i(ev[21]), .output_frequency_event_i(ev[20:9]), .crystal_short_term_error_i(ev[8:7]),
		.ppm_err_event_i(ev[6]), .ppm_warn_event_i(ev[5]), .crystal_signal_loss_event_i(ev[4:3]),
		.pll_lol_event_i(ev[2]), .self_test_event_i(ev[0]), .output_disable_o(output_disable_o),
		.safe_trigger_o(safe_trigger_o));

	task give_verdict;
		$display("checks=%0d mismatches=%0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task check_word(input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task check_flag(input logic exp, input logic got);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task reg_write(input logic [7:0] a, input logic [31:0] d);
		@(negedge ref_clk_i);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge ref_clk_i);
		reg_wr_i = 1'b0;
	endtask

	// one spare cycle before sampling; read data holds until the next read
	task reg_read(input logic [7:0] a, output logic [31:0] d);
		@(negedge ref_clk_i);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		@(negedge ref_clk_i);
		reg_rd_i = 1'b0;
		@(negedge ref_clk_i);
		d = reg_rdata_o;
	endtask

	task test_reset_state;
		reg_read(FAAE_ACTION_OFFSET, rd_val);
		check_word(FAAE_ACTION_RESET, rd_val);
		check_flag(1'b0, safe_trigger_o);
		check_word(32'h00000000, {20'h00000, output_disable_o});
	endtask

	task test_reg_access;
		reg_write(FAAE_ACTION_OFFSET, 32'hFFFFFFFF);
		reg_read(FAAE_ACTION_OFFSET, rd_val);
		check_word(32'h17FFFFFD, rd_val);
		reg_write(8'h04, 32'h00000000);
		reg_read(FAAE_ACTION_OFFSET, rd_val);
		check_word(32'h17FFFFFD, rd_val);
		reg_read(8'h04, rd_val);
		check_word(32'h00000000, rd_val);
		@(negedge ref_clk_i);
		srst_i = 1'b1;
		@(negedge ref_clk_i);
		srst_i = 1'b0;
		test_reset_state();
	endtask

	// the other-enables case catches a swapped or shifted bit mapping
	task test_event(input int b);
		logic [31:0] one;
		logic [31:0] dexp;
		one = 32'h00000001 << b;
		dexp = (b >= 9 && b <= 20) ? (32'h00000001 << (b - 9)) : 32'h00000000;
		reg_write(FAAE_ACTION_OFFSET, one);
		fault_en_i = one;
		ev = one;
		@(negedge ref_clk_i);
		check_flag(1'b1, safe_trigger_o);
		check_word(dexp, {20'h00000, output_disable_o});
		fault_en_i = ~one;
		@(negedge ref_clk_i);
		check_flag(1'b0, safe_trigger_o);
		check_word(dexp, {20'h00000, output_disable_o});
		reg_write(FAAE_ACTION_OFFSET, FAAE_ACTION_WMASK & ~one);
		fault_en_i = 32'hFFFFFFFF;
		@(negedge ref_clk_i);
		check_flag(1'b0, safe_trigger_o);
		check_word(32'h00000000, {20'h00000, output_disable_o});
		ev = 32'h00000000;
		fault_en_i = 32'h00000000;
		@(negedge ref_clk_i);
	endtask

	always @(posedge ref_clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			give_verdict();
		end
	end

	initial
	begin
		repeat (3) @(negedge ref_clk_i);
		srst_i = 1'b0;
		test_reset_state();
		test_reg_access();
		for (int b = 0; b < 32; b++)
			if (FAAE_ACTION_WMASK[b])
				test_event(b);
		give_verdict();
	end
endmodule
